/* sim/slc_remote_model.sv */
// Behavioural remote host that takes engine requests and answers them
`timescale 1ns/1ps
module slc_remote_model
    import slc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic tx_valid,
    input wire slc_tx_req_t tx_req,
    output logic tx_ready,
    output logic rx_valid,
    output slc_rx_resp_t rx_resp,
    input wire logic silent,
    input wire logic bad_src,
    input wire logic [HW_W-1:0] hw,
    output int tx_n,
    output logic [3:0] kinds,
    output slc_tx_req_t last_req
);
    int wait_cnt = 0;
    logic take;
    logic fire;
    slc_rx_resp_t reply;

    ////////////////////////////////////////////////////////////////////////////////
    // Reply mirrors the last request; a wrong source is sent only when asked for
    assign take = tx_valid && tx_ready;
    assign fire = !take && (wait_cnt == 1);
    assign reply = {slc_rx_kind_t'(last_req.kind), last_req.dest_v4 ^ {V4_W{bad_src}},
        last_req.dest_v6 ^ {V6_W{bad_src}}, hw, last_req.seq, last_req.id};

    ////////////////////////////////////////////////////////////////////////////////
    // Random stalls on transmit; idle reply lines toggle so stale data never matches
    always @(posedge clk_sys)
    begin
        tx_ready <= 1'($urandom_range(0, 1));
        rx_valid <= fire;
        rx_resp <= fire ? reply : ~rx_resp;
        if (!resetn)
        begin
            tx_n <= 0;
            kinds <= 4'h0;
            wait_cnt <= 0;
        end
        else if (take)
        begin
            tx_n <= tx_n + 1;
            kinds <= {kinds[1:0], tx_req.kind};
            last_req <= tx_req;
            wait_cnt <= silent ? 0 : $urandom_range(4, 40);
        end
        else if (wait_cnt > 0)
        begin
            wait_cnt <= wait_cnt - 1;
        end
    end
endmodule

/* sim/tb_socketless_command_engine.sv */
// Self-checking bench for the socketless command engine
`timescale 1ns/1ps
module tb_socketless_command_engine
    import slc_pkg::*;
();
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic command_wr = 1'b0;
    logic event_clear_wr = 1'b0;
    logic silent = 1'b0;
    logic bad_src = 1'b0;
    logic [CMD_W-1:0] command_wdata = 8'h00;
    logic [CMD_W-1:0] socketless_command;
    logic [FLAG_W-1:0] clr = 8'h00;
    logic [FLAG_W-1:0] mask = 8'hFF;
    logic [FLAG_W-1:0] flags;
    logic [FLAG_W-1:0] pending;
    logic [V4_W-1:0] ip4 = 32'h00000000;
    logic [V6_W-1:0] ip6 = 128'h0;
    logic [INTERVAL_W-1:0] interval = 16'h0001;
    logic [RETRY_CNT_W-1:0] rcount = 8'h03;
    logic [ECHO_W-1:0] seq = 16'h0000;
    logic [ECHO_W-1:0] id = 16'h0000;
    logic [HW_W-1:0] hw_out;
    logic [HW_W-1:0] hw_src = 48'h000000000000;
    logic tx_valid;
    logic tx_ready;
    logic rx_valid;
    slc_tx_req_t tx_req;
    slc_tx_req_t last_req;
    slc_rx_resp_t rx_resp;
    int tx_n;
    logic [3:0] kinds;
    int failures = 0;
    int checks_done = 0;

    always #20 clk_sys = ~clk_sys;

    slc_engine slc_engine_i (.clk_sys(clk_sys), .resetn(resetn), .command_wr(command_wr),
        .command_wdata(command_wdata), .socketless_command(socketless_command), .event_clear_wr(event_clear_wr),
        .socketless_event_clear(clr), .socketless_event_mask(mask), .socketless_event_flags(flags),
        .event_pending(pending), .sl_dest_ipv4_address(ip4), .sl_dest_ipv6_address(ip6),
        .sl_retry_interval(interval), .sl_retry_count(rcount), .echo_sequence_number(seq),
        .echo_identifier(id), .sl_dest_hw_address(hw_out), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_req(tx_req), .rx_valid(rx_valid), .rx_resp(rx_resp));

    slc_remote_model slc_remote_model_i (.clk_sys(clk_sys), .resetn(resetn), .tx_valid(tx_valid),
        .tx_req(tx_req), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_resp(rx_resp), .silent(silent),
        .bad_src(bad_src), .hw(hw_src), .tx_n(tx_n), .kinds(kinds), .last_req(last_req));

    ////////////////////////////////////////////////////////////////////////////////
    // Shared helpers: compare, settle after an edge, one-cycle write pulses
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic pulse_cmd(input logic [7:0] d);
        @(posedge clk_sys);
        command_wr <= 1'b1;
        command_wdata <= d;
        @(posedge clk_sys);
        command_wr <= 1'b0;
        #1;
    endtask

    task automatic pulse_clr(input logic [7:0] d);
        @(posedge clk_sys);
        event_clear_wr <= 1'b1;
        clr <= d;
        @(posedge clk_sys);
        event_clear_wr <= 1'b0;
        settle(1);
    endtask

    // Bounded wait; a missing flag shows up in the caller's comparison
    task automatic wait_flags(input int lim, output int n);
        n = 0;
        while (flags === 8'h00 && n < lim)
        begin
            settle(1);
            n++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // One command with a prompt remote, a refused write while busy, then clearing
    task automatic run_cmd(input int b);
        int n;
        int n0;
        logic echo;
        logic [7:0] bit_v;
        logic [1:0] res_k;
        logic [1:0] last_k;
        bit_v = 8'h01 << b;
        echo = (b == BIT_ECHO4) || (b == BIT_ECHO6);
        res_k = (b >= BIT_ECHO4) ? SLC_TX_ARP_REQ : SLC_TX_NS;
        last_k = (b == BIT_RESOLVE) ? SLC_TX_ARP_REQ : (b == BIT_ECHO4) ? SLC_TX_ECHO4_REQ :
            (b == BIT_ND) ? SLC_TX_NS : SLC_TX_ECHO6_REQ;
        @(posedge clk_sys);
        ip4 <= $urandom;
        ip6 <= {$urandom, $urandom, $urandom, $urandom};
        seq <= 16'($urandom);
        id <= 16'($urandom);
        hw_src <= 48'({$urandom, $urandom});
        mask <= 8'($urandom);
        n0 = tx_n;
        pulse_cmd((8'h0F << b) | 8'hF0);
        check(socketless_command, bit_v);
        pulse_cmd(8'h0F);
        check(socketless_command, bit_v);
        wait_flags(3000, n);
        check(flags, bit_v);
        check(hw_out, hw_src);
        check(pending, bit_v & mask);
        check(tx_n - n0, echo ? 2 : 1);
        check(echo ? kinds : kinds[1:0], echo ? {res_k, last_k} : last_k);
        if (b >= BIT_ECHO4)
            check(last_req.dest_v4, ip4);
        else
            check(last_req.dest_v6, ip6);
        if (b == BIT_ECHO4)
            check({last_req.seq, last_req.id}, {seq, id});
        settle(30);
        pulse_clr(~bit_v);
        check(socketless_command, 8'h00);
        check(flags, bit_v);
        pulse_clr(bit_v);
        check(flags, 8'h00);
        $display("test done: command bit %0d", b);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Resolution with a silent or wrong-source remote runs out of retries
    task automatic timeout_run(input int iv, input int rc, input logic bad);
        int n;
        int n0;
        int span;
        span = 2500 * iv * (rc + 1);
        @(posedge clk_sys);
        interval <= 16'(iv);
        rcount <= 8'(rc);
        silent <= !bad;
        bad_src <= bad;
        mask <= 8'h80;
        n0 = tx_n;
        pulse_cmd(8'h08);
        wait_flags(span + 1000, n);
        check(flags, 8'h80);
        check(tx_n - n0, rc + 1);
        check(n >= span - 2 && n <= span + 20 * (rc + 1), 1'b1);
        check(pending, 8'h80);
        settle(2);
        check(socketless_command, 8'h00);
        pulse_clr(8'h80);
        check(flags, 8'h00);
        $display("test done: timeout interval %0d count %0d", iv, rc);
    endtask

    task automatic end_sim;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Main sequence: reset state, each command, then two timeout cases
    initial
    begin
        void'($urandom(32'h8034a0e2));
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        settle(1);
        check({socketless_command, flags, pending, tx_valid}, 25'h0);
        check(hw_out, HW_RESET);
        $display("test done: reset state");
        for (int b = BIT_RESOLVE; b >= BIT_ECHO6; b--)
            run_cmd(b);
        timeout_run(1, 2, 1'b0);
        timeout_run(2, 0, 1'b1);
        end_sim();
    end

    // Watchdog well beyond the longest expected run
    initial
    begin
        repeat (40000) @(posedge clk_sys);
        failures++;
        $display("watchdog expired at %0t", $time);
        end_sim();
    end
endmodule

/* verilog/slc_engine.sv */
// Socketless command engine: command intake, request sequencing, retries and outcomes
`timescale 1ns/1ps
module slc_engine
    import slc_pkg::*;
#(
    parameter int RETRY_W = RETRY_CNT_W
)
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic command_wr,
    input wire logic [CMD_W-1:0] command_wdata,
    output logic [CMD_W-1:0] socketless_command,
    input wire logic event_clear_wr,
    input wire logic [FLAG_W-1:0] socketless_event_clear,
    input wire logic [FLAG_W-1:0] socketless_event_mask,
    output logic [FLAG_W-1:0] socketless_event_flags,
    output logic [FLAG_W-1:0] event_pending,
    input wire logic [V4_W-1:0] sl_dest_ipv4_address,
    input wire logic [V6_W-1:0] sl_dest_ipv6_address,
    input wire logic [INTERVAL_W-1:0] sl_retry_interval,
    input wire logic [RETRY_W-1:0] sl_retry_count,
    input wire logic [ECHO_W-1:0] echo_sequence_number,
    input wire logic [ECHO_W-1:0] echo_identifier,
    output logic [HW_W-1:0] sl_dest_hw_address,
    output logic tx_valid,
    input wire logic tx_ready,
    output slc_tx_req_t tx_req,
    input wire logic rx_valid,
    input wire slc_rx_resp_t rx_resp
);
    ////////////////////////////////////////////////////////////////////////
    // Declarations
    slc_state_t state;
    slc_state_t next_state;
    logic [CMD_W-1:0] active;
    logic [RETRY_W-1:0] retries;
    logic [HW_W-1:0] learned_hw;
    logic [FLAG_W-1:0] flag_set;
    logic [CMD_W-1:0] cmd_pick;
    logic cmd_take;
    logic is_v6;
    logic is_echo;
    logic waiting;
    logic sending;
    logic tx_fire;
    logic expire;
    logic rx_addr_ok;
    logic rx_res_match;
    logic rx_echo_match;
    logic res_done;
    logic echo_done;
    logic out_of_retries;
    logic retry_now;
    logic timeout_now;
    slc_tx_kind_t res_kind;
    slc_tx_kind_t echo_kind;
    slc_rx_kind_t res_reply;
    slc_rx_kind_t echo_reply;

    // Keep the lowest command bit only, so a multi-bit write still starts one command
    function automatic logic [CMD_W-1:0] lowest_cmd(input logic [CMD_W-1:0] bits);
        logic [CMD_W-1:0] masked;
        masked = bits & CMD_MASK;
        return masked & (~masked + 8'h01);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Command decode
    assign cmd_pick = lowest_cmd(command_wdata);
    assign cmd_take = command_wr && (state == SLC_IDLE) && (cmd_pick != '0);
    assign is_v6 = active[BIT_ND] || active[BIT_ECHO6];
    assign is_echo = active[BIT_ECHO4] || active[BIT_ECHO6];
    assign res_kind = is_v6 ? SLC_TX_NS : SLC_TX_ARP_REQ;
    assign echo_kind = is_v6 ? SLC_TX_ECHO6_REQ : SLC_TX_ECHO4_REQ;
    assign res_reply = is_v6 ? SLC_RX_NA : SLC_RX_ARP_REPLY;
    assign echo_reply = is_v6 ? SLC_RX_ECHO6_REPLY : SLC_RX_ECHO4_REPLY;

    // State classes
    assign waiting = (state == SLC_WAIT_RES) || (state == SLC_WAIT_ECHO);
    assign sending = (state == SLC_SEND_RES) || (state == SLC_SEND_ECHO);

    // Requests leave on the engine's private port; no socket is touched
    assign tx_valid = sending;
    assign tx_fire = tx_valid && tx_ready;

    ////////////////////////////////////////////////////////////////////////
    // Reply qualification: source must be the destination being asked about
    assign rx_addr_ok = is_v6 ? (rx_resp.src_v6 == tx_req.dest_v6) : (rx_resp.src_v4 == tx_req.dest_v4);
    assign rx_res_match = rx_valid && (state == SLC_WAIT_RES) && rx_addr_ok && (rx_resp.kind == res_reply);
    // IPv4 echo reply must echo back our sequence number and identifier
    assign rx_echo_match = rx_valid && (state == SLC_WAIT_ECHO) && rx_addr_ok && (rx_resp.kind == echo_reply)
        && (is_v6 || ((rx_resp.seq == tx_req.seq) && (rx_resp.id == tx_req.id)));

    // Outcomes; a reply in the expiry cycle wins, keeping one outcome only
    assign res_done = rx_res_match && !is_echo;
    assign echo_done = rx_echo_match;
    assign out_of_retries = (retries >= sl_retry_count);
    assign retry_now = waiting && expire && !rx_res_match && !rx_echo_match && !out_of_retries;
    assign timeout_now = waiting && expire && !rx_res_match && !rx_echo_match && out_of_retries;

    // Flags raised this cycle
    assign flag_set = ((res_done || echo_done) ? active : '0)
        | (timeout_now ? FLAG_W'(1 << BIT_TIMEOUT) : '0);

    // Mask gates each flag separately toward the pending output
    assign event_pending = socketless_event_flags & socketless_event_mask;

    // The register reads zero whenever no command is in progress
    assign socketless_command = active;

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        next_state = state;
        case (state)
            SLC_IDLE:
            begin
                if (cmd_take)
                    next_state = SLC_SEND_RES;
            end
            SLC_SEND_RES:
            begin
                if (tx_fire)
                    next_state = SLC_WAIT_RES;
            end
            SLC_WAIT_RES:
            begin
                if (rx_res_match)
                    next_state = is_echo ? SLC_SEND_ECHO : SLC_IDLE;
                else if (retry_now)
                    next_state = SLC_SEND_RES;
                else if (timeout_now)
                    next_state = SLC_IDLE;
            end
            SLC_SEND_ECHO:
            begin
                if (tx_fire)
                    next_state = SLC_WAIT_ECHO;
            end
            SLC_WAIT_ECHO:
            begin
                if (rx_echo_match || timeout_now)
                    next_state = SLC_IDLE;
                else if (retry_now)
                    next_state = SLC_SEND_ECHO;
            end
            default:
                next_state = SLC_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State and active command
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            state <= SLC_IDLE;
        else
            state <= next_state;
    end

    // Command stays visible until its outcome, then drops to zero
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            active <= CMD_RESET;
        else if (cmd_take)
            active <= cmd_pick;
        else if (flag_set != '0)
            active <= CMD_RESET;
    end

    ////////////////////////////////////////////////////////////////////////
    // Request snapshot: taken at command start so host writes mid-command cannot tear a retry
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            tx_req <= '0;
        else if (cmd_take)
        begin
            tx_req.kind <= (cmd_pick[BIT_ND] || cmd_pick[BIT_ECHO6]) ? SLC_TX_NS : SLC_TX_ARP_REQ;
            tx_req.dest_v4 <= sl_dest_ipv4_address;
            tx_req.dest_v6 <= sl_dest_ipv6_address;
            tx_req.seq <= echo_sequence_number;
            tx_req.id <= echo_identifier;
        end
        else if (rx_res_match && is_echo)
            tx_req.kind <= echo_kind;
        else if (state == SLC_IDLE)
            tx_req.kind <= res_kind;
    end

    // Retransmission count, shared by both phases of an echo command
    always_ff @(posedge clk_sys)
    begin
        if (!resetn || cmd_take)
            retries <= '0;
        else if (retry_now)
            retries <= retries + RETRY_W'(1);
    end

    ////////////////////////////////////////////////////////////////////////
    // Hardware address: learned on the resolution reply, published with the flag
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            learned_hw <= HW_RESET;
        else if (rx_res_match)
            learned_hw <= rx_resp.src_hw;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            sl_dest_hw_address <= HW_RESET;
        else if (res_done)
            sl_dest_hw_address <= rx_resp.src_hw;
        else if (echo_done)
            sl_dest_hw_address <= learned_hw;
    end

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    slc_retry_timer u_timer (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .restart(tx_fire),
        .run(waiting),
        .interval(sl_retry_interval),
        .expire(expire)
    );

    slc_event_flags #(.W(FLAG_W)) u_flags (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .set(flag_set),
        .clear_wr(event_clear_wr),
        .clear(socketless_event_clear),
        .flags(socketless_event_flags)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_busy_refuse: assert property (@(posedge clk_sys) disable iff (!resetn)
        (state != SLC_IDLE && command_wr) |=> (active == $past(active)) || ($past(flag_set) != '0))
        else $error("command accepted while another was running");

    a_cmd_clears: assert property (@(posedge clk_sys) disable iff (!resetn)
        (flag_set != '0) |=> (socketless_command == CMD_RESET) && (state == SLC_IDLE))
        else $error("command register not cleared after outcome");

    a_one_outcome: assert property (@(posedge clk_sys) disable iff (!resetn)
        (flag_set != '0) |-> $onehot(flag_set) && (state == SLC_WAIT_RES || state == SLC_WAIT_ECHO))
        else $error("more than one outcome flag for a command");

    a_timeout_cause: assert property (@(posedge clk_sys) disable iff (!resetn)
        flag_set[BIT_TIMEOUT] |-> expire && (retries >= sl_retry_count) && !rx_res_match && !rx_echo_match)
        else $error("timeout flag without expiry of the last retry");

    a_resend_req: assert property (@(posedge clk_sys) disable iff (!resetn)
        retry_now |=> tx_valid && (tx_req.kind == $past(tx_req.kind)) && (retries == $past(retries) + 8'h01))
        else $error("request not resent after retry interval");

    a_res_hw_store: assert property (@(posedge clk_sys) disable iff (!resetn)
        res_done |=> (sl_dest_hw_address == $past(rx_resp.src_hw))
            && (socketless_event_flags[BIT_RESOLVE] || socketless_event_flags[BIT_ND]))
        else $error("resolved hardware address not stored");

    a_echo_order: assert property (@(posedge clk_sys) disable iff (!resetn)
        (tx_valid && tx_req.kind == SLC_TX_ECHO4_REQ) |-> active[BIT_ECHO4] && (state == SLC_SEND_ECHO))
        else $error("echo request sent before address resolution");

    a_echo_fields: assert property (@(posedge clk_sys) disable iff (!resetn)
        cmd_take |=> (tx_req.seq == $past(echo_sequence_number)) && (tx_req.id == $past(echo_identifier)))
        else $error("echo request fields differ from host settings");

    a_echo_hw: assert property (@(posedge clk_sys) disable iff (!resetn)
        echo_done |=> (sl_dest_hw_address == $past(learned_hw)) && (state == SLC_IDLE))
        else $error("learned address not published with echo flag");

    a_late_ignored: assert property (@(posedge clk_sys) disable iff (!resetn)
        (state == SLC_IDLE) |-> (flag_set == '0) && !tx_valid)
        else $error("idle engine reacted to a late reply");

    a_mask_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
        ##1 ((event_pending & ~socketless_event_mask) == '0))
        else $error("masked flag reached the pending output");

    a_req_stable: assert property (@(posedge clk_sys) disable iff (!resetn)
        (tx_valid && !tx_ready) |=> tx_valid && $stable(tx_req))
        else $error("request changed before the transmitter took it");

    a_echo6_order: assert property (@(posedge clk_sys) disable iff (!resetn)
        (tx_valid && tx_req.kind == SLC_TX_ECHO6_REQ) |-> active[BIT_ECHO6] && (state == SLC_SEND_ECHO))
        else $error("IPv6 echo request sent before neighbour discovery");

    a_dest_snapshot: assert property (@(posedge clk_sys) disable iff (!resetn)
        cmd_take |=> (tx_req.dest_v4 == $past(sl_dest_ipv4_address))
            && (tx_req.dest_v6 == $past(sl_dest_ipv6_address)))
        else $error("request destination differs from host setting");

    a_hw_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
        !(res_done || echo_done) |=> $stable(sl_dest_hw_address))
        else $error("hardware address changed without a reply");
endmodule

/* verilog/slc_event_flags.sv */
// Sticky socketless event flags with write-one-to-clear
`timescale 1ns/1ps
module slc_event_flags
    import slc_pkg::*;
#(
    parameter int W = FLAG_W
)
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [W-1:0] set,
    input wire logic clear_wr,
    input wire logic [W-1:0] clear,
    output logic [W-1:0] flags
);
    logic [W-1:0] clear_mask;

    // Clear only takes effect on a write strobe
    assign clear_mask = clear_wr ? clear : '0;

    ////////////////////////////////////////////////////////////////////////
    // Set wins over a clear in the same cycle so no event is lost
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            flags <= W'(FLAG_RESET);
        else
            flags <= (flags & ~clear_mask) | set;
    end

    a_flag_sticky: assert property (@(posedge clk_sys) disable iff (!resetn)
        1'b1 |=> ((($past(flags) & ~$past(clear_mask)) & ~flags) == '0))
        else $error("event flag dropped without a clear");
    a_flag_set_wins: assert property (@(posedge clk_sys) disable iff (!resetn)
        (set != '0) |=> ((flags & $past(set)) == $past(set)))
        else $error("event flag set was lost");
endmodule

/* verilog/slc_pkg.sv */
// Package with constants, encodings and carriers for the socketless command engine
package slc_pkg;
    // System clock and the retransmission time unit
    localparam int CLK_HZ = 25_000_000;
    localparam int RETRY_UNIT_US = 100;
    localparam int RETRY_UNIT_CYCLES = (CLK_HZ / 1_000_000) * RETRY_UNIT_US;
    localparam int PRESCALE_W = 12;

    // Register widths
    localparam int CMD_W = 8;
    localparam int FLAG_W = 8;
    localparam int INTERVAL_W = 16;
    localparam int RETRY_CNT_W = 8;
    localparam int ECHO_W = 16;
    localparam int HW_W = 48;
    localparam int V4_W = 32;
    localparam int V6_W = 128;

    // Bit positions shared by the command, flag, clear and mask registers
    localparam int BIT_ECHO6 = 0;
    localparam int BIT_ND = 1;
    localparam int BIT_ECHO4 = 2;
    localparam int BIT_RESOLVE = 3;
    localparam int BIT_TIMEOUT = 7;
    localparam logic [CMD_W-1:0] CMD_MASK = 8'h0F;

    // Reset values
    localparam logic [CMD_W-1:0] CMD_RESET = 8'h00;
    localparam logic [FLAG_W-1:0] FLAG_RESET = 8'h00;
    localparam logic [HW_W-1:0] HW_RESET = 48'h000000000000;

    // Packet kinds toward the transmitter
    typedef enum logic [1:0] {
        SLC_TX_ARP_REQ = 2'b00,
        SLC_TX_ECHO4_REQ = 2'b01,
        SLC_TX_NS = 2'b10,
        SLC_TX_ECHO6_REQ = 2'b11
    } slc_tx_kind_t;

    // Reply kinds from the receiver
    typedef enum logic [1:0] {
        SLC_RX_ARP_REPLY = 2'b00,
        SLC_RX_ECHO4_REPLY = 2'b01,
        SLC_RX_NA = 2'b10,
        SLC_RX_ECHO6_REPLY = 2'b11
    } slc_rx_kind_t;

    // Engine states
    typedef enum logic [2:0] {
        SLC_IDLE = 3'b000,
        SLC_SEND_RES = 3'b001,
        SLC_WAIT_RES = 3'b010,
        SLC_SEND_ECHO = 3'b011,
        SLC_WAIT_ECHO = 3'b100
    } slc_state_t;

    typedef struct packed {
        slc_tx_kind_t kind;
        logic [V4_W-1:0] dest_v4;
        logic [V6_W-1:0] dest_v6;
        logic [ECHO_W-1:0] seq;
        logic [ECHO_W-1:0] id;
    } slc_tx_req_t;

    typedef struct packed {
        slc_rx_kind_t kind;
        logic [V4_W-1:0] src_v4;
        logic [V6_W-1:0] src_v6;
        logic [HW_W-1:0] src_hw;
        logic [ECHO_W-1:0] seq;
        logic [ECHO_W-1:0] id;
    } slc_rx_resp_t;
endpackage

/* verilog/slc_retry_timer.sv */
// Retransmission timer counting in 100 microsecond units
`timescale 1ns/1ps
module slc_retry_timer
    import slc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic restart,
    input wire logic run,
    input wire logic [INTERVAL_W-1:0] interval,
    output logic expire
);
    logic [PRESCALE_W-1:0] prescale;
    logic [INTERVAL_W-1:0] units;
    logic tick;
    logic last_unit;

    // A zero interval behaves as one unit so the engine never spins
    assign tick = run && (prescale == PRESCALE_W'(RETRY_UNIT_CYCLES - 1));
    assign last_unit = (units + 16'h0001 >= interval);
    assign expire = tick && last_unit;

    ////////////////////////////////////////////////////////////////////////
    // Prescaler and unit counter, both cleared by each send
    always_ff @(posedge clk_sys)
    begin
        if (!resetn || restart || !run)
        begin
            prescale <= '0;
            units <= '0;
        end
        else if (tick)
        begin
            prescale <= '0;
            units <= units + 16'h0001;
        end
        else
        begin
            prescale <= prescale + 12'h001;
        end
    end

    a_unit_period: assert property (@(posedge clk_sys) disable iff (!resetn)
        restart |=> (!expire) [*8])
        else $error("retry timer expired too early after restart");
endmodule
